// file: pkg/pmu_regs.svh
`ifndef PMU_REGS_SVH
`define PMU_REGS_SVH
// Operation
// - The unit has exactly five power modes (normal, idle, stop, suspend, sleep) and controls entry and wake from each.
// - Idle halts the CPU with peripherals running, and any interrupt returns to normal.
// - Stop halts the CPU and disables the precision oscillator; only a reset leaves it.
// - Suspend wake resumes at the next instruction without a reset.
// - Sleep gates the clock and stops every oscillator like suspend, gates the supply, wakes like suspend, and the comparator works only in two-cell mode.
// - Setting bit 6 of the power configuration register gates the system clock and stops all internal oscillators.
// - While suspended the CPU, timers, comms and interrupt logic stay frozen until an enabled wake source fires.
// - Wake flags take two clocks to update after suspend wake and read zero meanwhile.
// - Oscillator fail, alarm, port match and comparator rising edge are each enableable wake sources.
// - A reset-pin pulse too short to reset still ends suspend.
// - The configuration register shows a flag for wake by reset-pin falling edge.
// - After any other wake source an immediate return to suspend is accepted.

// Register byte addresses
`define PMU_ADDR_CFG 4'h0
`define PMU_ADDR_CTRL 4'h4
`define PMU_ADDR_IRQ_STAT 4'h8
`define PMU_ADDR_IRQ_MASK 4'hC
// Configuration register fields
`define PMU_CFG_SLEEP_BIT 7
`define PMU_CFG_SUSPEND_BIT 6
`define PMU_CFG_STOP_BIT 5
`define PMU_CFG_IDLE_BIT 4
`define PMU_WAKE_W 5
// Wake flag positions: osc fail, alarm, port match, comparator, reset pin
`define PMU_WK_OSCF 0
`define PMU_WK_ALRM 1
`define PMU_WK_PMAT 2
`define PMU_WK_CMP 3
`define PMU_WK_RSTP 4
// Control register fields
`define PMU_CTRL_TWOCELL_BIT 0
`define PMU_CTRL_SETTLE_BIT 1
`define PMU_CTRL_RSTP_BIT 2
// Reset values
`define PMU_WAKE_EN_RST 5'h00
// Timing
`define PMU_CLK_HZ 20000000
`define PMU_FLAG_SETTLE_CLKS 2
`define PMU_RSTP_HOLD_NS 15000
`define PMU_RSTP_HOLD_CLKS ((`PMU_RSTP_HOLD_NS * (`PMU_CLK_HZ / 1000000) + 999) / 1000)
`endif

// file: pkg/pmu_pkg.sv
package pmu_pkg;
  typedef enum logic [2:0] {
    PMU_NORMAL = 3'b000,
    PMU_IDLE = 3'b001,
    PMU_STOP = 3'b010,
    PMU_SUSPEND = 3'b011,
    PMU_SLEEP = 3'b100
  } pmu_mode_t;
  typedef struct packed {
    logic osc_fail;
    logic alarm;
    logic port_match;
    logic cmp_out;
    logic rst_pin_n;
  } pmu_wake_in_t;
  typedef struct packed {
    logic clk_gate;
    logic osc_off;
    logic prec_osc_off;
    logic supply_gate;
    logic cpu_halt;
  } pmu_pwr_out_t;
endpackage

// file: rtl/pmu_wake_detect.sv
`timescale 1ns/1ps
`include "pmu_regs.svh"
module pmu_wake_detect
  import pmu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input pmu_wake_in_t i_src,
  input wire logic i_cmp_allowed,
  output logic [`PMU_WAKE_W-1:0] o_event
);
  logic cmp_q_reg;
  logic rstp_q_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_q_reg <= 1'b0;
      rstp_q_reg <= 1'b1;
    end else begin
      cmp_q_reg <= i_src.cmp_out;
      rstp_q_reg <= i_src.rst_pin_n;
    end
  end
  always_comb begin
    o_event = '0;
    o_event[`PMU_WK_OSCF] = i_src.osc_fail;
    o_event[`PMU_WK_ALRM] = i_src.alarm;
    o_event[`PMU_WK_PMAT] = i_src.port_match;
    o_event[`PMU_WK_CMP] = i_src.cmp_out & ~cmp_q_reg & i_cmp_allowed;
    o_event[`PMU_WK_RSTP] = rstp_q_reg & ~i_src.rst_pin_n;
  end
endmodule

// file: rtl/pmu_power_mgmt_unit.sv
`timescale 1ns/1ps
`include "pmu_regs.svh"
module pmu_power_mgmt_unit
  import pmu_pkg::*;
#(
  parameter int WAKE_W = `PMU_WAKE_W
)(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input pmu_wake_in_t i_wake_src,
  input wire logic i_any_irq,
  input wire logic i_sys_reset_req,
  output pmu_pwr_out_t o_pwr,
  output pmu_mode_t o_mode,
  output logic o_irq
);
  // ****************************************
  // Declarations
  // ****************************************
  pmu_mode_t mode_reg;
  pmu_mode_t mode_next;
  logic [WAKE_W-1:0] wake_en_reg;
  logic [WAKE_W-1:0] wake_flag_reg;
  logic [WAKE_W-1:0] irq_stat_reg;
  logic [WAKE_W-1:0] irq_mask_reg;
  logic [WAKE_W-1:0] wake_ev;
  logic two_cell_reg;
  logic [1:0] settle_reg;
  logic [9:0] rstp_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic susp_cmd;
  logic sleep_cmd;
  logic wake_hit;

  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  pmu_wake_detect u_detect (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_src(i_wake_src),
    .i_cmp_allowed((mode_reg != PMU_SLEEP) | two_cell_reg),
    .o_event(wake_ev)
  );

  // ****************************************
  // Avalon slave: one wait cycle per access
  // ****************************************
  assign req = (i_avs_read | i_avs_write) & ~ack_reg;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr_cfg = i_avs_write & ack_reg & addr_is(i_avs_address, `PMU_ADDR_CFG)
    & i_avs_byteenable[0];
  assign wr_ctrl = i_avs_write & ack_reg & addr_is(i_avs_address, `PMU_ADDR_CTRL)
    & i_avs_byteenable[0];
  assign wr_mask = i_avs_write & ack_reg & addr_is(i_avs_address, `PMU_ADDR_IRQ_MASK)
    & i_avs_byteenable[0];
  assign rd_stat = i_avs_read & ack_reg & addr_is(i_avs_address, `PMU_ADDR_IRQ_STAT);
  assign susp_cmd = wr_cfg & i_avs_writedata[`PMU_CFG_SUSPEND_BIT]
    & (rstp_cnt_reg == 10'h000);
  assign sleep_cmd = wr_cfg & i_avs_writedata[`PMU_CFG_SLEEP_BIT]
    & (rstp_cnt_reg == 10'h000);
  assign wake_hit = |(wake_ev & wake_en_reg);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 32'h00000000;
    end else if (req & i_avs_read) begin
      rdata_reg <= 32'h00000000;
      if (addr_is(i_avs_address, `PMU_ADDR_CFG)) begin
        rdata_reg[WAKE_W-1:0] <= (settle_reg != 2'h0) ? '0 : wake_flag_reg;
        rdata_reg[`PMU_CFG_SUSPEND_BIT] <= (mode_reg == PMU_SUSPEND);
        rdata_reg[`PMU_CFG_SLEEP_BIT] <= (mode_reg == PMU_SLEEP);
      end else if (addr_is(i_avs_address, `PMU_ADDR_CTRL)) begin
        rdata_reg[`PMU_CTRL_TWOCELL_BIT] <= two_cell_reg;
        rdata_reg[`PMU_CTRL_SETTLE_BIT] <= (settle_reg != 2'h0);
        rdata_reg[`PMU_CTRL_RSTP_BIT] <= (rstp_cnt_reg != 10'h000);
        rdata_reg[8 +: WAKE_W] <= wake_en_reg;
      end else if (addr_is(i_avs_address, `PMU_ADDR_IRQ_STAT)) begin
        rdata_reg[WAKE_W-1:0] <= irq_stat_reg;
      end else if (addr_is(i_avs_address, `PMU_ADDR_IRQ_MASK)) begin
        rdata_reg[WAKE_W-1:0] <= irq_mask_reg;
      end
    end
  end
  assign o_avs_readdata = rdata_reg;

  // ****************************************
  // Configuration
  // ****************************************
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      wake_en_reg <= `PMU_WAKE_EN_RST;
      two_cell_reg <= 1'b0;
    end else if (wr_ctrl) begin
      two_cell_reg <= i_avs_writedata[`PMU_CTRL_TWOCELL_BIT];
      wake_en_reg <= i_avs_writedata[8 +: WAKE_W];
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= i_avs_writedata[WAKE_W-1:0];
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  logic low_mode;
  assign low_mode = (mode_reg == PMU_SUSPEND) | (mode_reg == PMU_SLEEP);

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      PMU_NORMAL: begin
        if (sleep_cmd) begin
          mode_next = PMU_SLEEP;
        end else if (susp_cmd) begin
          mode_next = PMU_SUSPEND;
        end else if (wr_cfg & i_avs_writedata[`PMU_CFG_STOP_BIT]) begin
          mode_next = PMU_STOP;
        end else if (wr_cfg & i_avs_writedata[`PMU_CFG_IDLE_BIT]) begin
          mode_next = PMU_IDLE;
        end
      end
      PMU_IDLE: begin
        if (i_any_irq) begin
          mode_next = PMU_NORMAL;
        end
      end
      PMU_STOP: begin
        mode_next = PMU_STOP;
      end
      PMU_SUSPEND: begin
        if (wake_hit) begin
          mode_next = PMU_NORMAL;
        end
      end
      PMU_SLEEP: begin
        if (wake_hit) begin
          mode_next = PMU_NORMAL;
        end
      end
      default: begin
        mode_next = PMU_NORMAL;
      end
    endcase
    if (i_sys_reset_req) begin
      mode_next = PMU_NORMAL;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_reg <= PMU_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end
  assign o_mode = mode_reg;

  always_comb begin
    o_pwr.clk_gate = low_mode;
    o_pwr.osc_off = low_mode;
    o_pwr.prec_osc_off = low_mode | (mode_reg == PMU_STOP);
    o_pwr.supply_gate = (mode_reg == PMU_SLEEP);
    o_pwr.cpu_halt = (mode_reg != PMU_NORMAL);
  end

  // ****************************************
  // Wake flags, settle and reset-pin hold
  // ****************************************
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      settle_reg <= 2'h0;
    end else if (low_mode & wake_hit) begin
      settle_reg <= 2'(`PMU_FLAG_SETTLE_CLKS);
    end else if (settle_reg != 2'h0) begin
      settle_reg <= settle_reg - 2'h1;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      wake_flag_reg <= '0;
    end else if (low_mode & wake_hit) begin
      wake_flag_reg <= wake_flag_reg | (wake_ev & wake_en_reg);
    end else if (wr_cfg) begin
      wake_flag_reg <= wake_flag_reg & i_avs_writedata[WAKE_W-1:0];
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rstp_cnt_reg <= 10'h000;
    end else if (low_mode & wake_hit & wake_ev[`PMU_WK_RSTP] & wake_en_reg[`PMU_WK_RSTP]) begin
      rstp_cnt_reg <= 10'(`PMU_RSTP_HOLD_CLKS);
    end else if (rstp_cnt_reg != 10'h000) begin
      rstp_cnt_reg <= rstp_cnt_reg - 10'h001;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      irq_stat_reg <= '0;
    end else begin
      // Clear only what the read returned; a new event still sets
      irq_stat_reg <= (rd_stat ? (irq_stat_reg & ~rdata_reg[WAKE_W-1:0]) : irq_stat_reg)
        | (low_mode ? (wake_ev & wake_en_reg) : '0);
    end
  end
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // Checks
  // ****************************************
  sequence s_wake;
    low_mode && wake_hit;
  endsequence
  sequence s_settle;
    (settle_reg != 2'h0) [*2];
  endsequence

  chk_susp_gates: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    mode_reg == PMU_SUSPEND |-> o_pwr.clk_gate && o_pwr.osc_off)
    else $error("suspend without clock gate");
  chk_wake_resume: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_wake and !i_sys_reset_req |=> mode_reg == PMU_NORMAL)
    else $error("no resume after wake");
  chk_settle_len: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_wake |=> s_settle ##1 settle_reg == 2'h0)
    else $error("settle not two clocks");
  chk_stop_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    mode_reg == PMU_STOP && !i_sys_reset_req |=> mode_reg == PMU_STOP)
    else $error("stop left without reset");
  chk_idle_wake: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    mode_reg == PMU_IDLE && i_any_irq |=> mode_reg == PMU_NORMAL)
    else $error("idle not woken");
  chk_frozen: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    low_mode && !wake_hit && !i_sys_reset_req |=> low_mode && o_pwr.cpu_halt)
    else $error("suspend left without source");
  chk_rstp_flag: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_wake and (wake_ev[`PMU_WK_RSTP] && wake_en_reg[`PMU_WK_RSTP])
    |=> wake_flag_reg[`PMU_WK_RSTP] && rstp_cnt_reg != 10'h000)
    else $error("reset pin flag missing");
  chk_flag_sticky: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    wake_flag_reg != '0 && !wr_cfg |=> wake_flag_reg != '0)
    else $error("wake flag lost");
  chk_sleep_supply: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    mode_reg == PMU_SLEEP |-> o_pwr.supply_gate)
    else $error("sleep without supply gate");
  chk_resuspend: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    mode_reg == PMU_NORMAL && rstp_cnt_reg == 10'h000 && wr_cfg && !i_sys_reset_req
    && i_avs_writedata[`PMU_CFG_SUSPEND_BIT] && !i_avs_writedata[`PMU_CFG_SLEEP_BIT]
    |=> mode_reg == PMU_SUSPEND)
    else $error("suspend refused");
endmodule

// file: verification/pmu_wake_model.sv
`timescale 1ns/1ps
// ********************
// Wake source model
// ********************
module pmu_wake_model
  import pmu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [4:0] i_fire,
  output pmu_wake_in_t o_src
);
  logic [4:0] act_reg;
  logic [1:0] cnt_reg;
  // Each event lasts four clocks, then the source goes quiet
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      act_reg <= 5'h00;
      cnt_reg <= 2'h0;
    end else if (|i_fire) begin
      act_reg <= i_fire;
      cnt_reg <= 2'h3;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end else begin
      act_reg <= 5'h00;
    end
  end
  // Pin glitch low, pulled back high; comparator edge rises with act
  assign o_src = {act_reg[0], act_reg[1], act_reg[2], act_reg[3], ~act_reg[4]};
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import pmu_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq;
  logic any_irq;
  logic sys_rst;
  logic irq;
  logic [4:0] fire;
  pmu_wake_in_t src;
  pmu_pwr_out_t pwr;
  pmu_mode_t mode;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  pmu_power_mgmt_unit u_pmu_power_mgmt_unit (
    .I_CLK_SYS(clk), .I_RST(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_wake_src(src),
    .i_any_irq(any_irq), .i_sys_reset_req(sys_rst), .o_pwr(pwr), .o_mode(mode),
    .o_irq(irq)
  );

  pmu_wake_model u_pmu_wake_model (.i_clk(clk), .i_rst(rst), .i_fire(fire), .o_src(src));

  // ********************
  // Helpers
  // ********************
  task automatic summarize;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      t++;
    end while (waitreq !== 1'b0 && t < 20);
    if (t >= 20) n_mismatch++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask

  task automatic pulse(input logic [4:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 5'h00;
  endtask

  task automatic wmode(input pmu_mode_t m);
    int t;
    t = 0;
    while (mode !== m && t < 60) begin
      @(posedge clk);
      t++;
    end
    check(32'(mode), 32'(m));
  endtask

  task automatic line_pulse(input int which);
    @(posedge clk);
    if (which == 0) any_irq <= 1'b1;
    else sys_rst <= 1'b1;
    @(posedge clk);
    any_irq <= 1'b0;
    sys_rst <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ********************
  // Tests
  // ********************
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    any_irq = 1'b0;
    sys_rst = 1'b0;
    fire = 5'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(mode), 32'(PMU_NORMAL));
    check(32'(pwr), 32'h0);
    rdchk(4'h0, 32'h0);
    rdchk(4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h10);
    wmode(PMU_IDLE);
    check(32'(pwr.cpu_halt), 32'h1);
    line_pulse(0);
    wmode(PMU_NORMAL);
    bus(1'b1, 4'h0, 32'h20);
    wmode(PMU_STOP);
    check(32'(pwr.prec_osc_off), 32'h1);
    line_pulse(0);
    pulse(5'h02);
    repeat (5) @(posedge clk);
    check(32'(mode), 32'(PMU_STOP));
    line_pulse(1);
    wmode(PMU_NORMAL);
    // Sources disabled: nothing may wake; two-cell mode and irq mask set first
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b1, 4'hC, 32'h1F);
    bus(1'b1, 4'h0, 32'h40);
    wmode(PMU_SUSPEND);
    check(32'(pwr), 32'h1D);
    pulse(5'h0F);
    line_pulse(0);
    repeat (5) @(posedge clk);
    check(32'(mode), 32'(PMU_SUSPEND));
    bus(1'b0, 4'h8, 32'h0);
    bus(1'b1, 4'h4, 32'h1F01);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) bus(1'b1, 4'hC, 32'h0);
      if (k > 0) bus(1'b1, 4'h0, 32'h40);
      wmode(PMU_SUSPEND);
      pulse(5'(1 << k));
      wmode(PMU_NORMAL);
      rdchk(4'h0, 32'h1 << k);
      rdchk(4'h0, 32'h1 << k);
      check(32'(irq), 32'(k != 4));
      rdchk(4'h8, 32'h1 << k);
      rdchk(4'h8, 32'h0);
      check(32'(irq), 32'h0);
    end
    // Pin wake: early re-suspend refused until the hold ends
    bus(1'b1, 4'h0, 32'h40);
    repeat (3) @(posedge clk);
    check(32'(mode), 32'(PMU_NORMAL));
    rdchk(4'h4, 32'h1F05);
    repeat (310) @(posedge clk);
    rdchk(4'h4, 32'h1F01);
    bus(1'b1, 4'h4, 32'h1F00);
    bus(1'b1, 4'h0, 32'h80);
    wmode(PMU_SLEEP);
    check(32'(pwr.supply_gate), 32'h1);
    pulse(5'h08);
    repeat (5) @(posedge clk);
    check(32'(mode), 32'(PMU_SLEEP));
    bus(1'b1, 4'h4, 32'h1F01);
    pulse(5'h08);
    rdchk(4'h0, 32'h0);
    wmode(PMU_NORMAL);
    rdchk(4'h0, 32'h08);
    summarize();
  end
endmodule
